// File: core/fsl_defs.svh
/*
  Opcodes, bit counts, codes and timing for the serial-flash
  security/parameter/lock instruction block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef FSL_DEFS_SVH
`define FSL_DEFS_SVH
// Instruction opcodes
`define FSL_OP_SFDP    8'h5A
`define FSL_OP_SR_ERS  8'h44
`define FSL_OP_SR_PGM  8'h42
`define FSL_OP_SR_RD   8'h48
`define FSL_OP_LOCK    8'h36
`define FSL_OP_UNLOCK  8'h39
`define FSL_OP_LK_RD   8'h3D
`define FSL_OP_STATUS  8'h05
// Rising-edge counts closing each field
`define FSL_CNT_OP     6'h08
`define FSL_CNT_ADDR   6'h20
`define FSL_CNT_DUMMY  6'h28
`define FSL_CNT_MAX    6'h3F
// Security register address decode
`define FSL_SR_FIRST   4'h1
`define FSL_SR_LAST    4'h3
`define FSL_BYTE_FF    8'hFF
`define FSL_MEM_LAST   10'h2FF
// Lock bit map: 128 blocks, then 16+16 sectors
`define FSL_LK_BITS    160
`define FSL_BLK_LAST   7'h7F
`define FSL_LK_BOT     8'h80
`define FSL_LK_TOP     8'h90
`define FSL_BLKS       8'h80
`define FSL_SECTS      8'h10
// Status byte bit positions
`define FSL_ST_BUSY    0
`define FSL_ST_WEL     1
// Self-timed cycle lengths
`define FSL_CLK_MHZ    100
`define FSL_T_ERASE_US 50
`define FSL_T_PROG_US  10
`endif

// File: core/fsl_pkg.sv
/*
  Types of the instruction block.
  Assumes nothing of its surroundings.
*/
package fsl_pkg;
  typedef enum logic [1:0] {
    FSL_ST_IDLE = 2'h0,
    FSL_ST_WORK = 2'h1,
    FSL_ST_DONE = 2'h3
  } fsl_state_e;
  typedef enum logic [1:0] {
    FSL_K_INIT  = 2'h0,
    FSL_K_ERASE = 2'h1,
    FSL_K_PROG  = 2'h2
  } fsl_kind_e;
endpackage : fsl_pkg

// File: core/fsl_cmd.sv
/*
  Serial-flash instruction block: parameter table read, security
  register erase/program/read, block lock/unlock/read-back.
  Assumes a mode-0 serial host; the link logic runs on i_sclk, the
  self-timed cycles on i_clk. Link fields are read by the core when chip
  select rises; a program cycle keeps reading the staged data while a new frame clocks in, except that a new program opcode clears pvld_r.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsl_defs.svh"

module fsl_cmd #(
  parameter int ERASE_CYCLES = `FSL_T_ERASE_US * `FSL_CLK_MHZ,
  parameter logic [7:0] SFDP_SEED = 8'hA5  // Arbitrary table content seed
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_serial_in,
  output var  logic        o_serial_out,
  output var  logic        o_serial_out_oe,
  input  wire logic        i_wel_set,
  input  wire logic        i_wel_clr,
  input  wire logic [2:0]  i_otp_lock_bits,
  input  wire logic        i_protect_scheme_select,
  input  wire logic        i_complement_protect,
  input  wire logic        i_sector_granularity,
  input  wire logic        i_top_bottom_select,
  input  wire logic [2:0]  i_protect_range_bits,
  input  wire logic [23:0] i_query_addr,
  output var  logic        o_query_protected,
  output var  logic        o_busy,
  output var  logic        o_write_enable_latch
);
  localparam int PROG_CYCLES = `FSL_T_PROG_US * `FSL_CLK_MHZ;
  localparam int TW = 20;

  // Lock bit index: whole blocks, sectors in first and last block
  function automatic logic [7:0] lock_idx(input logic [23:0] a);
    if (a[22:16] == 7'h00) lock_idx = `FSL_LK_BOT + {4'h0, a[15:12]};
    else if (a[22:16] == `FSL_BLK_LAST) lock_idx = `FSL_LK_TOP + {4'h0, a[15:12]};
    else lock_idx = {1'b0, a[22:16]};
  endfunction : lock_idx

  // Security register address is well formed
  function automatic logic sr_ok(input logic [23:0] a);
    sr_ok = (a[23:16] == 8'h00) && (a[11:8] == 4'h0) &&
            (a[15:12] >= `FSL_SR_FIRST) && (a[15:12] <= `FSL_SR_LAST);
  endfunction : sr_ok

  function automatic logic [1:0] sr_idx(input logic [23:0] a);
    sr_idx = a[13:12] - 2'h1;
  endfunction : sr_idx

  // Rising edges that precede the data phase of an opcode
  function automatic logic [5:0] hdr_len(input logic [7:0] op);
    case (op)
      `FSL_OP_SFDP, `FSL_OP_SR_RD: hdr_len = `FSL_CNT_DUMMY;
      `FSL_OP_STATUS:              hdr_len = `FSL_CNT_OP;
      `FSL_OP_SR_PGM, `FSL_OP_LK_RD: hdr_len = `FSL_CNT_ADDR;
      default:                     hdr_len = `FSL_CNT_MAX;
    endcase
  endfunction : hdr_len

  // Parameter table content
  function automatic logic [7:0] sfdp_byte(input logic [7:0] i);
    sfdp_byte = i ^ SFDP_SEED;
  endfunction : sfdp_byte

  // Link domain (i_sclk) state
  logic       frame_rst_n;
  logic       first_r;
  logic [5:0] cnt_r, cnt_nxt, cnt_cur;
  logic [7:0] sh_r, sh_nxt, byte_in;
  logic [7:0] op_r, op_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [2:0] bitc_r, bitc_nxt;
  logic [7:0] bytec_r, bytec_nxt;
  logic       ign_r, ign_nxt, pany_r, pany_nxt, tog_r, tog_nxt;
  logic [255:0] pvld_r, pvld_nxt;
  logic [7:0] pbuf_r [0:255];
  logic       buf_we;
  logic [7:0] buf_wa;
  logic [1:0] ls1_r, ls2_r, ls3_r, lf_r, lf_nxt;  // {wel, busy}
  logic       so_r, so_nxt, oe_r, oe_nxt;
  logic [7:0] rd_byte, rd_ptr;
  // Core domain state, declared ahead of the link logic that reads it
  fsl_pkg::fsl_state_e st_r, st_nxt;
  fsl_pkg::fsl_kind_e  kind_r, kind_nxt;
  logic [1:0]  cs1_r, cs2_r, cs3_r, csf_r, csf_nxt;  // {tog, cs_n}
  logic        csp_r, seen_r, seen_nxt, rise, busy;
  logic        wel_r, wel_nxt, prot_r, prot_nxt, in_rng;
  logic [9:0]  ptr_r, ptr_nxt, end_r, end_nxt;
  logic [TW-1:0] tim_r, tim_nxt;
  logic [`FSL_LK_BITS-1:0] lock_r, lock_nxt;
  logic [7:0]  mem_r [0:767];
  logic        mem_we, start;
  logic [7:0]  mem_wd, rng_n, blk8, sec8;

  assign frame_rst_n = i_rst_n & ~i_cs_n;

  // Frame start marker, set while chip select is high
  always_ff @(posedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) first_r <= 1'b1;
    else              first_r <= 1'b0;
  end

  // Core status into the link clock, change taken once stages agree
  always_comb begin
    lf_nxt = ((ls2_r ~^ ls3_r) & ls2_r) | ((ls2_r ^ ls3_r) & lf_r);
  end

  // Instruction capture next state
  always_comb begin
    cnt_cur   = first_r ? 6'h00 : cnt_r;
    byte_in   = {sh_r[6:0], i_serial_in};
    sh_nxt    = byte_in;
    cnt_nxt   = (cnt_cur == `FSL_CNT_MAX) ? cnt_cur : cnt_cur + 6'h01;
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    bitc_nxt  = bitc_r;
    bytec_nxt = bytec_r;
    ign_nxt   = ign_r;
    pany_nxt  = pany_r;
    pvld_nxt  = pvld_r;
    tog_nxt   = first_r ? ~tog_r : tog_r;
    buf_we    = 1'b0;
    buf_wa    = addr_r[7:0] + bytec_r;
    if (cnt_cur == `FSL_CNT_OP - 6'h01) begin
      op_nxt    = byte_in;
      bitc_nxt  = 3'h0;
      bytec_nxt = 8'h00;
      ign_nxt   = lf_r[`FSL_ST_BUSY];
      pany_nxt  = 1'b0;
      if (byte_in == `FSL_OP_SR_PGM) pvld_nxt = '0;
    end else if (cnt_cur >= hdr_len(op_r)) begin
      bitc_nxt = bitc_r + 3'h1;
      if (bitc_r == 3'h7) bytec_nxt = bytec_r + 8'h01;
      if (op_r == `FSL_OP_SR_PGM && !ign_r && bitc_r == 3'h7) begin
        buf_we           = 1'b1;
        pvld_nxt[buf_wa] = 1'b1;
        pany_nxt         = 1'b1;
      end
    end else if (cnt_cur < `FSL_CNT_ADDR) begin
      addr_nxt = {addr_r[22:0], i_serial_in};
    end
  end

  // Instruction capture registers
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 6'h00; sh_r <= 8'h00; op_r <= 8'h00; addr_r <= 24'h000000;
      bitc_r <= 3'h0; bytec_r <= 8'h00; ign_r <= 1'b0; pany_r <= 1'b0;
      tog_r <= 1'b0; pvld_r <= '0;
      ls1_r <= 2'h0; ls2_r <= 2'h0; ls3_r <= 2'h0; lf_r <= 2'h0;
    end else begin
      cnt_r <= cnt_nxt; sh_r <= sh_nxt; op_r <= op_nxt; addr_r <= addr_nxt;
      bitc_r <= bitc_nxt; bytec_r <= bytec_nxt; ign_r <= ign_nxt;
      pany_r <= pany_nxt; tog_r <= tog_nxt; pvld_r <= pvld_nxt;
      ls1_r <= {wel_r, busy}; ls2_r <= ls1_r; ls3_r <= ls2_r; lf_r <= lf_nxt;
    end
  end

  // Program data staging
  always_ff @(posedge i_sclk) begin
    if (buf_we) pbuf_r[buf_wa] <= byte_in;
  end

  // Output byte select and bit on the falling edge
  always_comb begin
    rd_ptr = addr_r[7:0] + bytec_r;
    case (op_r)
      `FSL_OP_SFDP:   rd_byte = (addr_r[23:8] == 16'h0000) ?
                                sfdp_byte(rd_ptr) : `FSL_BYTE_FF;
      `FSL_OP_SR_RD:  rd_byte = sr_ok(addr_r) ?
                                mem_r[{sr_idx(addr_r), rd_ptr}] : `FSL_BYTE_FF;
      `FSL_OP_LK_RD:  rd_byte = {7'h00, lock_r[lock_idx(addr_r)]};
      `FSL_OP_STATUS: rd_byte = {6'h00, lf_r};
      default:        rd_byte = `FSL_BYTE_FF;
    endcase
    oe_nxt = !first_r && cnt_r >= `FSL_CNT_OP && cnt_r >= hdr_len(op_r) &&
             op_r != `FSL_OP_SR_PGM && hdr_len(op_r) != `FSL_CNT_MAX &&
             (op_r == `FSL_OP_STATUS || !ign_r);
    so_nxt = oe_nxt & rd_byte[~bitc_r];  // MSB first
  end

  // Serial output, released when chip select is high
  always_ff @(negedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      so_r <= so_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign o_serial_out    = so_r;
  assign o_serial_out_oe = oe_r;

  // Core domain (i_clk): busy flag and filtered chip select rise
  assign busy = (st_r != fsl_pkg::FSL_ST_IDLE);
  assign rise = csf_r[0] & ~csp_r;

  // Chip select and frame marker filter, change taken once stages agree
  always_comb begin
    csf_nxt = ((cs2_r ~^ cs3_r) & cs2_r) | ((cs2_r ^ cs3_r) & csf_r);
  end

  // Command execution and self-timed cycle
  always_comb begin
    st_nxt = st_r; kind_nxt = kind_r; ptr_nxt = ptr_r; end_nxt = end_r;
    tim_nxt = tim_r; lock_nxt = lock_r; seen_nxt = seen_r;
    wel_nxt = wel_r; mem_we = 1'b0; mem_wd = `FSL_BYTE_FF; start = 1'b0;
    if (i_wel_clr) wel_nxt = 1'b0;
    case (st_r)
      fsl_pkg::FSL_ST_IDLE: begin
        if (rise && csf_r[1] != seen_r) begin
          seen_nxt = csf_r[1];
          case (op_r)
            `FSL_OP_SR_ERS: begin
              start    = cnt_r == `FSL_CNT_ADDR && wel_r && sr_ok(addr_r) &&
                         !i_otp_lock_bits[sr_idx(addr_r)];
              kind_nxt = fsl_pkg::FSL_K_ERASE;
              tim_nxt  = TW'(ERASE_CYCLES);
            end
            `FSL_OP_SR_PGM: begin
              start    = pany_r && !ign_r && wel_r && sr_ok(addr_r) &&
                         !i_otp_lock_bits[sr_idx(addr_r)];
              kind_nxt = fsl_pkg::FSL_K_PROG;
              tim_nxt  = TW'(PROG_CYCLES);
            end
            `FSL_OP_LOCK: if (cnt_r == `FSL_CNT_ADDR && wel_r)
              lock_nxt[lock_idx(addr_r)] = 1'b1;
            `FSL_OP_UNLOCK: if (cnt_r == `FSL_CNT_ADDR && wel_r)
              lock_nxt[lock_idx(addr_r)] = 1'b0;
            default: ;
          endcase
          if (start) begin
            st_nxt  = fsl_pkg::FSL_ST_WORK;
            ptr_nxt = {sr_idx(addr_r), 8'h00};
            end_nxt = {sr_idx(addr_r), 8'hFF};
          end else begin
            kind_nxt = kind_r;
            tim_nxt  = tim_r;
          end
        end else if (rise) begin
          seen_nxt = csf_r[1];
        end
      end
      fsl_pkg::FSL_ST_WORK: begin
        mem_we = 1'b1;
        if (kind_r == fsl_pkg::FSL_K_PROG)
          mem_wd = mem_r[ptr_r] &
                   (pvld_r[ptr_r[7:0]] ? pbuf_r[ptr_r[7:0]] : `FSL_BYTE_FF);
        if (ptr_r != end_r) ptr_nxt = ptr_r + 10'h001;
        if (tim_r != '0) tim_nxt = tim_r - TW'(1);
        if (rise) seen_nxt = csf_r[1];  // Frames during busy dropped
        if (ptr_r == end_r && tim_r == '0) st_nxt = fsl_pkg::FSL_ST_DONE;
      end
      fsl_pkg::FSL_ST_DONE: begin
        if (kind_r != fsl_pkg::FSL_K_INIT) wel_nxt = 1'b0;
        if (rise) seen_nxt = csf_r[1];
        st_nxt = fsl_pkg::FSL_ST_IDLE;
      end
      default: st_nxt = fsl_pkg::FSL_ST_IDLE;
    endcase
    if (i_wel_set) wel_nxt = 1'b1;
  end

  // Array protection for the queried address
  always_comb begin
    rng_n = (i_protect_range_bits == 3'h0) ? 8'h00 :
            8'h01 << (i_protect_range_bits - 3'h1);
    blk8  = {1'b0, i_query_addr[22:16]};
    sec8  = {4'h0, i_query_addr[15:12]};
    if (i_sector_granularity)
      in_rng = i_top_bottom_select ?
               (blk8 == 8'h00 && sec8 < rng_n) :
               (blk8 == {1'b0, `FSL_BLK_LAST} && sec8 + rng_n >= `FSL_SECTS);
    else
      in_rng = i_top_bottom_select ? (blk8 < rng_n) : (blk8 + rng_n >= `FSL_BLKS);
    prot_nxt = i_protect_scheme_select ? lock_r[lock_idx(i_query_addr)] :
               (in_rng ^ i_complement_protect);
  end

  // Core registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= fsl_pkg::FSL_ST_WORK; kind_r <= fsl_pkg::FSL_K_INIT;
      ptr_r <= 10'h000; end_r <= `FSL_MEM_LAST; tim_r <= '0;
      lock_r <= '1;
      wel_r <= 1'b0; prot_r <= 1'b1; seen_r <= 1'b0; csp_r <= 1'b1;
      cs1_r <= 2'h1; cs2_r <= 2'h1; cs3_r <= 2'h1; csf_r <= 2'h1;
    end else begin
      st_r <= st_nxt; kind_r <= kind_nxt; ptr_r <= ptr_nxt; end_r <= end_nxt;
      tim_r <= tim_nxt; lock_r <= lock_nxt; wel_r <= wel_nxt;
      prot_r <= prot_nxt; seen_r <= seen_nxt; csp_r <= csf_r[0];
      cs1_r <= {tog_r, i_cs_n}; cs2_r <= cs1_r; cs3_r <= cs2_r;
      csf_r <= csf_nxt;
    end
  end

  // Security register storage
  always_ff @(posedge i_clk) begin
    if (mem_we) mem_r[ptr_r] <= mem_wd;
  end

  assign o_busy               = busy;
  assign o_write_enable_latch = wel_r;
  assign o_query_protected    = prot_r;
endmodule : fsl_cmd
`default_nettype wire

// File: tb/fsl_host.sv
/*
  Serial host model: mode-0 frames on a 12 ns link clock.
  Assumes the device samples on rise and shifts out on fall.
*/
`timescale 1ns/1ps
`default_nettype none
module fsl_host (
  output var  logic o_sclk,
  output var  logic o_cs_n,
  output var  logic o_si,
  input  wire logic i_so
);
  logic [7:0] rx [4];
  // Opcode, ab address bits, dm dummies, nw bytes out from wb, nr bytes in
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int ab,
                       input int dm, input int nw, input int nr, input logic [7:0] wb);
    logic [31:0] hd;
    logic [7:0]  b;
    int          h;
    int          r;
    hd = {op, a};
    h = 8 + ab + dm;
    o_cs_n = 1'b0;
    for (int k = 0; k < h + 8 * (nw + nr); k++) begin
      #3;
      b = wb + 8'((k - h) / 8);
      if (k < 8 + ab) o_si = hd[31 - k];
      else if (k < h) o_si = k[0];
      else o_si = b[7 - (k - h) % 8];
      #3 o_sclk = 1'b1;
      r = k - h - 8 * nw;
      if (r >= 0) rx[r / 8][7 - r % 8] = i_so;
      #6 o_sclk = 1'b0;
    end
    // Raise select right after the last bit, clock stays low
    #3 o_cs_n = 1'b1;
    o_si = ~o_si;
    #120;
  endtask : frame
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end
endmodule : fsl_host
`default_nettype wire

// File: tb/fsl_cmd_props.sv
/*
  Checker for the instruction block ports.
  Assumes binding onto fsl_cmd; link counter reset by select.
*/
`timescale 1ns/1ps
`default_nettype none
module fsl_cmd_props (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_sclk,
  input wire logic       i_cs_n,
  input wire logic       i_wel_set,
  input wire logic       i_protect_scheme_select,
  input wire logic       i_complement_protect,
  input wire logic [2:0] i_protect_range_bits,
  input wire logic       o_serial_out_oe,
  input wire logic       o_query_protected,
  input wire logic       o_busy,
  input wire logic       o_write_enable_latch
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  // Rising link edges in the current frame
  always_comb cnt_nxt = (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;
  always_ff @(posedge i_sclk or posedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n || i_cs_n) cnt_r <= 6'h00;
    else cnt_r <= cnt_nxt;
  end
  a_lock_reset_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) && i_protect_scheme_select |=> o_query_protected)
    else $error("protect low after reset");
  a_wel_needs_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_write_enable_latch) |-> $past(i_wel_set)) else $error("latch set unasked");
  a_done_clears_wel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_busy) && !$past(i_wel_set) |-> !o_write_enable_latch)
    else $error("latch kept after cycle");
  a_busy_needs_wel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_busy) |-> $past(o_write_enable_latch)) else $error("cycle without latch");
  a_busy_after_cs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2)) else $error("cycle before select high");
  a_busy_min_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_busy) |-> $past(o_busy, 8)) else $error("cycle too short");
  a_out_start_edge: assert property (@(posedge i_sclk) disable iff (!i_rst_n)
    $rose(o_serial_out_oe) |-> cnt_r inside {6'h08, 6'h20, 6'h28})
    else $error("output starts at wrong edge");
  a_range_scheme: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n && !i_protect_scheme_select && i_protect_range_bits == 3'h0)
    |-> o_query_protected == $past(i_complement_protect)) else $error("range protect wrong");
  c_busy: cover property (@(posedge i_clk) $rose(o_busy));
  c_read: cover property (@(posedge i_sclk) $rose(o_serial_out_oe) && cnt_r == 6'h28);
  c_wel_drop: cover property (@(posedge i_clk) $fell(o_write_enable_latch));
endmodule : fsl_cmd_props
bind fsl_cmd fsl_cmd_props fsl_cmd_props_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_wel_set(i_wel_set),
  .i_protect_scheme_select(i_protect_scheme_select),
  .i_complement_protect(i_complement_protect), .i_protect_range_bits(i_protect_range_bits),
  .o_serial_out_oe(o_serial_out_oe), .o_query_protected(o_query_protected),
  .o_busy(o_busy), .o_write_enable_latch(o_write_enable_latch));
`default_nettype wire

// File: tb/fsl_cmd_test.sv
/*
  Testbench: serial frames through the host model, port checks.
  Assumes fsl_cmd, fsl_host and the bound checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module fsl_cmd_test;
  localparam logic [7:0] SEED = 8'hA5; // Arbitrary table seed
  logic clk, rst_n, sclk, cs_n, si, so, oe, ws, wc, protect_scheme_select, cmp, sec, tbs, prot, busy, write_enable_latch;
  logic [2:0]  otp;
  logic [2:0]  bp;
  logic [23:0] qa;
  int          failures;
  int          num_checks;
  fsl_cmd #(.ERASE_CYCLES(300), .SFDP_SEED(SEED)) fsl_cmd_inst (.i_clk(clk),
    .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_in(si), .o_serial_out(so),
    .o_serial_out_oe(oe), .i_wel_set(ws), .i_wel_clr(wc), .i_otp_lock_bits(otp),
    .i_protect_scheme_select(protect_scheme_select), .i_complement_protect(cmp), .i_sector_granularity(sec),
    .i_top_bottom_select(tbs), .i_protect_range_bits(bp), .i_query_addr(qa),
    .o_query_protected(prot), .o_busy(busy), .o_write_enable_latch(write_enable_latch));
  fsl_host fsl_host_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so));
  // Core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wait_idle;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) cyc(1);
    chk("idle_wait", {7'h0, busy}, 8'h00);
  endtask : wait_idle
  task automatic pulse_set;
    ws = 1'b1;
    cyc(1);
    ws = 1'b0;
    cyc(1);
  endtask : pulse_set
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int dm,
                      input int nw, input int nr, input logic [7:0] wb);
    fsl_host_inst.frame(op, a, 24, dm, nw, nr, wb);
    cyc(3);
  endtask : send
  task automatic prot_is(input logic c, input logic t, input logic [2:0] b,
                         input logic [23:0] a, input logic e);
    cmp = c;
    tbs = t;
    bp = b;
    qa = a;
    cyc(2);
    chk("range_protect", {7'h0, prot}, {7'h0, e});
  endtask : prot_is
  // Watchdog
  initial begin
    #400000;
    failures++;
    stop_test();
  end
  // Main sequence
  initial begin
    {rst_n, ws, wc, cmp, sec, tbs} = 6'h00;
    {otp, bp, protect_scheme_select, qa} = {3'h0, 3'h0, 1'b1, 24'h010000};
    failures = 0;
    num_checks = 0;
    cyc(10);
    rst_n = 1'b1;
    wait_idle();
    chk("lock_reset", {7'h0, prot}, 8'h01);
    send(8'h5A, 24'h0000FE, 8, 0, 3, 8'h00);
    chk("table_fe", fsl_host_inst.rx[0], 8'hFE ^ SEED);
    chk("table_wrap", fsl_host_inst.rx[2], 8'h00 ^ SEED);
    send(8'h5A, 24'h010000, 8, 0, 1, 8'h00);
    chk("table_bad", fsl_host_inst.rx[0], 8'hFF);
    send(8'h44, 24'h002000, 0, 0, 0, 8'h00);
    send(8'h42, 24'h0020FE, 0, 1, 0, 8'h77);
    chk("no_latch", {7'h0, busy}, 8'h00);
    pulse_set();
    send(8'h42, 24'h0020FE, 0, 3, 0, 8'h11);
    chk("prog_busy", {7'h0, busy}, 8'h01);
    wait_idle();
    send(8'h48, 24'h0020FE, 8, 0, 4, 8'h00);
    chk("rd_fe", fsl_host_inst.rx[0], 8'h11);
    chk("rd_wrap", fsl_host_inst.rx[2], 8'h13);
    chk("rd_blank", fsl_host_inst.rx[3], 8'hFF);
    pulse_set();
    send(8'h44, 24'h002000, 1, 0, 0, 8'h00);
    chk("erase_long", {6'h0, write_enable_latch, busy}, 8'h02);
    send(8'h44, 24'h002000, 0, 0, 0, 8'h00);
    send(8'h48, 24'h0020FE, 8, 0, 1, 8'h00);
    chk("rd_busy", fsl_host_inst.rx[0], 8'h00);
    send(8'h05, 24'h000000, 0, 0, 0, 8'h00);
    fsl_host_inst.frame(8'h05, 24'h0, 0, 0, 0, 2, 8'h00);
    chk("status_busy", fsl_host_inst.rx[1], 8'h03);
    wait_idle();
    chk("erase_wel", {7'h0, write_enable_latch}, 8'h00);
    send(8'h48, 24'h0020FE, 8, 0, 1, 8'h00);
    chk("erased", fsl_host_inst.rx[0], 8'hFF);
    otp = 3'h1;
    pulse_set();
    send(8'h42, 24'h001000, 0, 1, 0, 8'h55);
    chk("otp_busy", {6'h0, write_enable_latch, busy}, 8'h02);
    otp = 3'h0;
    send(8'h44, 24'h002100, 0, 0, 0, 8'h00);
    chk("sr_bad_addr", {6'h0, write_enable_latch, busy}, 8'h02);
    send(8'h48, 24'h001000, 8, 0, 1, 8'h00);
    chk("otp_data", fsl_host_inst.rx[0], 8'hFF);
    send(8'h39, 24'h010000, 0, 0, 0, 8'h00);
    chk("unlock", {7'h0, prot}, 8'h00);
    send(8'h3D, 24'h010000, 0, 0, 1, 8'h00);
    chk("lk_rd0", fsl_host_inst.rx[0], 8'h00);
    send(8'h36, 24'h010000, 0, 0, 0, 8'h00);
    chk("lock", {6'h0, write_enable_latch, prot}, 8'h03);
    send(8'h3D, 24'h010000, 0, 0, 1, 8'h00);
    chk("lk_rd1", fsl_host_inst.rx[0], 8'h01);
    wc = 1'b1;
    cyc(1);
    wc = 1'b0;
    send(8'h39, 24'h010000, 0, 0, 0, 8'h00);
    chk("unlock_nolatch", {6'h0, write_enable_latch, prot}, 8'h01);
    protect_scheme_select = 1'b0;
    prot_is(1'b0, 1'b0, 3'h0, 24'h010000, 1'b0);
    prot_is(1'b1, 1'b0, 3'h0, 24'h010000, 1'b1);
    prot_is(1'b0, 1'b0, 3'h1, 24'h7F0000, 1'b1);
    prot_is(1'b0, 1'b0, 3'h1, 24'h010000, 1'b0);
    prot_is(1'b0, 1'b1, 3'h1, 24'h000000, 1'b1);
    sec = 1'b1;
    prot_is(1'b0, 1'b0, 3'h1, 24'h7FF000, 1'b1);
    prot_is(1'b0, 1'b0, 3'h1, 24'h7FE000, 1'b0);
    prot_is(1'b0, 1'b1, 3'h2, 24'h001000, 1'b1);
    stop_test();
  end
endmodule : fsl_cmd_test
`default_nettype wire
